// ### rtl/abd_regs.svh
`ifndef ABD_REGS_SVH
`define ABD_REGS_SVH
`define ABD_ZERO8       8'h00
`define ABD_ONES8       8'hff
`define ABD_ONE8        8'h01
`define ABD_ZERO16      16'h0000
`define ABD_ONE16       16'h0001
`define ABD_SKIP1       16'h0002
`define ABD_SKIP2       16'h0003
`define ABD_PC_RST      16'h0000
`define ABD_SP_RST      16'h045f
`define ABD_SP_STEP     16'h0002
`define ABD_CYC_ONE     2'h0
`define ABD_CYC_TWO     2'h1
`define ABD_CYC_THREE   2'h2
`define ABD_CYC_FOUR    2'h3
`define ABD_FLAG_C      0
`define ABD_FLAG_Z      1
`define ABD_FLAG_N      2
`define ABD_FLAG_V      3
`define ABD_FLAG_S      4
`define ABD_FLAG_H      5
`define ABD_FLAG_I      7
`define ABD_SREG_RST    8'h00
`endif

// ### rtl/abd_pkg.sv
package abd_pkg;
  typedef enum logic [4:0] {
    ABD_OP_NOP        = 5'h00,
    ABD_OP_ADD        = 5'h01,
    ABD_OP_ADD_CARRY  = 5'h02,
    ABD_OP_PAIR_SUM   = 5'h03,
    ABD_OP_SUB        = 5'h04,
    ABD_OP_MINUS_K    = 5'h05,
    ABD_OP_MINUS_BRW  = 5'h06,
    ABD_OP_MINUS_KBRW = 5'h07,
    ABD_OP_PAIR_MINUS = 5'h08,
    ABD_OP_AND        = 5'h09,
    ABD_OP_MASK_K     = 5'h0a,
    ABD_OP_OR         = 5'h0b,
    ABD_OP_MERGE_K    = 5'h0c,
    ABD_OP_XOR        = 5'h0d,
    ABD_OP_INVERT     = 5'h0e,
    ABD_OP_ARITH_INV  = 5'h0f,
    ABD_OP_SET_BITS   = 5'h10,
    ABD_OP_CLEAR_BITS = 5'h11,
    ABD_OP_INC        = 5'h12,
    ABD_OP_DEC        = 5'h13,
    ABD_OP_ZS_CHECK   = 5'h14,
    ABD_OP_CLEAR_REG  = 5'h15,
    ABD_OP_SET_REG    = 5'h16,
    ABD_OP_MUL        = 5'h17,
    ABD_OP_FRACTION_PRODUCT_UNSIGNED       = 5'h18,
    ABD_OP_REL_BRANCH = 5'h19,
    ABD_OP_IND_BRANCH = 5'h1a,
    ABD_OP_REL_INVOKE = 5'h1b,
    ABD_OP_IND_INVOKE = 5'h1c,
    ABD_OP_SUB_EXIT   = 5'h1d,
    ABD_OP_INT_EXIT   = 5'h1e,
    ABD_OP_EQUAL_SKIP = 5'h1f
  } abd_op_t;

  typedef enum logic [1:0] {
    ABD_MUL_UU = 2'h0,
    ABD_MUL_SS = 2'h1,
    ABD_MUL_SU = 2'h2
  } abd_mul_mode_t;

  typedef enum logic [1:0] {
    ABD_ST_IDLE = 2'b00,
    ABD_ST_BUSY = 2'b01
  } abd_state_t;

  typedef struct packed {
    abd_state_t  state;
    logic [1:0]  left;
    abd_op_t     op;
    logic [7:0]  sreg;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] pend_pc;
    logic [15:0] res;
    logic        wr_byte;
    logic        wr_pair;
    logic        wr_prod;
    logic        push;
    logic        pop;
    logic        done;
    logic        busy;
  } abd_state_s_t;
endpackage : abd_pkg

// ### rtl/abd_mul.sv
`timescale 1ns/100ps
`default_nettype none
`include "abd_regs.svh"
module abd_mul
  import abd_pkg::*;
(
  input  wire logic          core_clk,   // Core clock
  input  wire logic          srst,       // Synchronous reset
  input  wire logic [7:0]    a,          // Destination operand
  input  wire logic [7:0]    b,          // Source operand
  input  wire abd_mul_mode_t mode,       // Operand signedness
  input  wire logic          frac,       // Shift product left by one
  output logic      [15:0]   prod_q,     // Registered product
  output logic               carry_q     // Product bit 15 before shift
);
  logic signed [8:0]  sa;
  logic signed [8:0]  sb;
  logic signed [17:0] full;
  logic [15:0]        raw;

  always_comb
  begin
    sa   = (mode == ABD_MUL_UU) ? $signed({1'b0, a}) : $signed({a[7], a});
    sb   = (mode == ABD_MUL_SS) ? $signed({b[7], b}) : $signed({1'b0, b});
    full = sa * sb;
    raw  = full[15:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      prod_q  <= `ABD_ZERO16;
      carry_q <= 1'b0;
    end
    else
    begin
      prod_q  <= frac ? {raw[14:0], 1'b0} : raw;
      carry_q <= raw[15];
    end
  end
endmodule : abd_mul
`default_nettype wire

// ### rtl/abd_datapath.sv
// Summary of operation
// - Add two registers, optional carry, flags Z C N V H, one cycle.
// - Subtract register, optional borrow, flags Z C N V H, one cycle.
// - Subtract constant from register, flags Z C N V H, one cycle.
// - Subtract constant and carry, flags Z C N V H, one cycle.
// - Pair add immediate on 16 bits, flags Z C N V S, two cycles.
// - Pair subtract immediate on 16 bits, flags Z C N V S, two cycles.
// - AND with register or constant, flags Z N V only, one cycle.
// - OR, XOR, OR constant, flags Z N V only, one cycle.
// - Set bits ORs mask; increment, decrement change only Z N V.
// - Clear bits ANDs inverted mask; set register changes no flag.
// - Zero/sign check ANDs register with itself; clear XORs with itself.
// - Invert is ff minus reg, Z C N V; negate is zero minus reg.
// - Unsigned, signed, mixed multiply into pair 1:0, flags Z C, two cycles.
// - Fractional multiplies shift product left one, flags Z C, two cycles.
// - Relative branch/invoke load pc plus offset plus one; two/three cycles.
// - Indirect branch loads pc from Z pointer, no flags, two cycles.
// - Indirect invoke three cycles; subroutine and interrupt exit four cycles.
// - Equal skip advances pc by 2 or 3 when equal, no flags.
`timescale 1ns/100ps
`default_nettype none
`include "abd_regs.svh"
module abd_datapath
  import abd_pkg::*;
(
  input  wire logic          core_clk,     // Core clock
  input  wire logic          srst,         // Synchronous reset
  input  wire logic          start,        // Issue op this cycle when not busy
  input  wire abd_op_t       op,           // Operation code
  input  wire abd_mul_mode_t mul_mode,     // Multiply signedness
  input  wire logic [7:0]    dst_val,      // Destination register value
  input  wire logic [7:0]    src_reg,      // Source register value
  input  wire logic [7:0]    imm,          // Immediate constant
  input  wire logic [15:0]   pair_val,     // High:low pair for pair ops
  input  wire logic [15:0]   z_ptr,        // Z pointer pair
  input  wire logic [11:0]   offset,       // Signed relative offset
  input  wire logic          next_is_long, // Skipped instruction is two words
  input  wire logic [15:0]   pop_data,     // Return address read from stack
  output logic               busy,         // Multi-cycle op in progress
  output logic               done,         // Op completed, one cycle
  output logic      [15:0]   result,       // Byte in low bits, or pair/product
  output logic               wr_byte,      // Write result[7:0] to destination
  output logic               wr_pair,      // Write result to destination pair
  output logic               wr_prod,      // Write result to pair 1:0
  output logic      [7:0]    sreg,         // Status flags
  output logic      [15:0]   pc,           // Program counter
  output logic      [15:0]   sp,           // Stack pointer
  output logic               push,         // Push pc_ret, one cycle
  output logic               pop,          // Stack pop done, one cycle
  output logic      [15:0]   push_data     // Return address to push
);
  import abd_pkg::*;

  abd_state_s_t s_q;
  abd_state_s_t s_d;
  logic [15:0]  prod_q;
  logic         prod_c_q;
  logic [15:0]  push_data_q;
  logic [15:0]  push_data_d;
  logic [8:0]   sum9;
  logic [7:0]   b8;
  logic [7:0]   a8;
  logic [7:0]   r8;
  logic         h_c;
  logic         v_c;
  logic         c_c;
  logic [15:0]  r16;
  logic [15:0]  rel_pc;
  logic         is_sub;
  logic         cin;
  abd_mul u_mul (
    .core_clk (core_clk),
    .srst     (srst),
    .a        (dst_val),
    .b        (src_reg),
    .mode     (mul_mode),
    .frac     (op == ABD_OP_FRACTION_PRODUCT_UNSIGNED),
    .prod_q   (prod_q),
    .carry_q  (prod_c_q)
  );
  always_comb
  begin
    s_d         = s_q;
    push_data_d = push_data_q;
    s_d.done    = 1'b0;
    s_d.wr_byte = 1'b0;
    s_d.wr_pair = 1'b0;
    s_d.wr_prod = 1'b0;
    s_d.push    = 1'b0;
    s_d.pop     = 1'b0;
    a8     = dst_val;
    b8     = src_reg;
    cin    = 1'b0;
    is_sub = 1'b0;
    r8     = `ABD_ZERO8;
    sum9   = 9'h000;
    h_c    = 1'b0;
    v_c    = 1'b0;
    c_c    = 1'b0;
    r16    = `ABD_ZERO16;
    rel_pc = s_q.pc + {{4{offset[11]}}, offset} + `ABD_ONE16;
    unique case (op)
      ABD_OP_ADD_CARRY:  cin = s_q.sreg[`ABD_FLAG_C];
      ABD_OP_SUB, ABD_OP_MINUS_K: is_sub = 1'b1;
      ABD_OP_MINUS_BRW, ABD_OP_MINUS_KBRW:
      begin
        is_sub = 1'b1;
        cin    = s_q.sreg[`ABD_FLAG_C];
      end
      ABD_OP_ARITH_INV:
      begin
        is_sub = 1'b1;
        a8     = `ABD_ZERO8;
        b8     = dst_val;
      end
      default:           cin = 1'b0;
    endcase
    if (op == ABD_OP_MINUS_K || op == ABD_OP_MINUS_KBRW)
      b8 = imm;
    if (is_sub)
    begin
      sum9 = {1'b0, a8} - {1'b0, b8} - {8'h00, cin};
      r8   = sum9[7:0];
      h_c  = (~a8[3] & b8[3]) | (b8[3] & r8[3]) | (r8[3] & ~a8[3]);
      v_c  = (a8[7] & ~b8[7] & ~r8[7]) | (~a8[7] & b8[7] & r8[7]);
      c_c  = sum9[8];
    end
    else
    begin
      sum9 = {1'b0, a8} + {1'b0, b8} + {8'h00, cin};
      r8   = sum9[7:0];
      h_c  = (a8[3] & b8[3]) | (b8[3] & ~r8[3]) | (~r8[3] & a8[3]);
      v_c  = (a8[7] & b8[7] & ~r8[7]) | (~a8[7] & ~b8[7] & r8[7]);
      c_c  = sum9[8];
    end
    if (s_q.state == ABD_ST_IDLE)
    begin
      if (start)
      begin
        s_d.op = op;
        unique case (op)
          ABD_OP_ADD, ABD_OP_ADD_CARRY, ABD_OP_SUB, ABD_OP_MINUS_K,
          ABD_OP_MINUS_BRW, ABD_OP_MINUS_KBRW, ABD_OP_ARITH_INV:
          begin
            s_d.res                    = {8'h00, r8};
            s_d.sreg[`ABD_FLAG_H]      = h_c;
            s_d.sreg[`ABD_FLAG_C]      = c_c;
            s_d.sreg[`ABD_FLAG_V]      = v_c;
            s_d.sreg[`ABD_FLAG_N]      = r8[7];
            // Borrow forms keep Z when result is zero
            s_d.sreg[`ABD_FLAG_Z]      = (r8 == `ABD_ZERO8) &
              ((op != ABD_OP_MINUS_BRW && op != ABD_OP_MINUS_KBRW) |
               s_q.sreg[`ABD_FLAG_Z]);
            s_d.wr_byte = 1'b1;
            s_d.done    = 1'b1;
          end
          ABD_OP_AND, ABD_OP_MASK_K, ABD_OP_OR, ABD_OP_MERGE_K, ABD_OP_XOR,
          ABD_OP_SET_BITS, ABD_OP_CLEAR_BITS, ABD_OP_ZS_CHECK, ABD_OP_CLEAR_REG,
          ABD_OP_INVERT:
          begin
            unique case (op)
              ABD_OP_AND:        r8 = dst_val & src_reg;
              ABD_OP_MASK_K:     r8 = dst_val & imm;
              ABD_OP_OR:         r8 = dst_val | src_reg;
              ABD_OP_XOR:        r8 = dst_val ^ src_reg;
              ABD_OP_CLEAR_BITS: r8 = dst_val & (`ABD_ONES8 - imm);
              ABD_OP_ZS_CHECK:   r8 = dst_val & dst_val;
              ABD_OP_CLEAR_REG:  r8 = dst_val ^ dst_val;
              ABD_OP_INVERT:     r8 = `ABD_ONES8 - dst_val;
              default:           r8 = dst_val | imm;
            endcase
            s_d.res               = {8'h00, r8};
            s_d.sreg[`ABD_FLAG_V] = 1'b0;
            s_d.sreg[`ABD_FLAG_N] = r8[7];
            s_d.sreg[`ABD_FLAG_Z] = (r8 == `ABD_ZERO8);
            if (op == ABD_OP_INVERT)
              s_d.sreg[`ABD_FLAG_C] = 1'b1;
            s_d.wr_byte = 1'b1;
            s_d.done    = 1'b1;
          end
          ABD_OP_INC, ABD_OP_DEC:
          begin
            r8 = (op == ABD_OP_INC) ? dst_val + `ABD_ONE8 : dst_val - `ABD_ONE8;
            v_c = (op == ABD_OP_INC) ? (dst_val == 8'h7f) : (dst_val == 8'h80);
            s_d.res               = {8'h00, r8};
            s_d.sreg[`ABD_FLAG_V] = v_c;
            s_d.sreg[`ABD_FLAG_N] = r8[7];
            s_d.sreg[`ABD_FLAG_Z] = (r8 == `ABD_ZERO8);
            s_d.wr_byte = 1'b1;
            s_d.done    = 1'b1;
          end
          ABD_OP_SET_REG:
          begin
            s_d.res     = {8'h00, `ABD_ONES8};
            s_d.wr_byte = 1'b1;
            s_d.done    = 1'b1;
          end
          ABD_OP_EQUAL_SKIP:
          begin
            if (dst_val == src_reg)
            begin
              s_d.pend_pc = s_q.pc + (next_is_long ? `ABD_SKIP2 : `ABD_SKIP1);
              s_d.left    = next_is_long ? `ABD_CYC_TWO : `ABD_CYC_ONE;
              s_d.state   = ABD_ST_BUSY;
              s_d.busy    = 1'b1;
            end
            else
            begin
              s_d.pc   = s_q.pc + `ABD_ONE16;
              s_d.done = 1'b1;
            end
          end
          ABD_OP_PAIR_SUM, ABD_OP_PAIR_MINUS, ABD_OP_MUL, ABD_OP_FRACTION_PRODUCT_UNSIGNED,
          ABD_OP_REL_BRANCH, ABD_OP_IND_BRANCH:
          begin
            s_d.pend_pc = (op == ABD_OP_IND_BRANCH) ? z_ptr : rel_pc;
            s_d.left    = `ABD_CYC_ONE;
            s_d.state   = ABD_ST_BUSY;
            s_d.busy    = 1'b1;
            if (op == ABD_OP_PAIR_SUM)
              s_d.res = pair_val + {10'h000, imm[5:0]};
            else if (op == ABD_OP_PAIR_MINUS)
              s_d.res = pair_val - {10'h000, imm[5:0]};
          end
          ABD_OP_REL_INVOKE, ABD_OP_IND_INVOKE:
          begin
            s_d.pend_pc = (op == ABD_OP_IND_INVOKE) ? z_ptr : rel_pc;
            push_data_d = s_q.pc + `ABD_ONE16;
            s_d.push    = 1'b1;
            s_d.sp      = s_q.sp - `ABD_SP_STEP;
            s_d.left    = `ABD_CYC_TWO;
            s_d.state   = ABD_ST_BUSY;
            s_d.busy    = 1'b1;
          end
          ABD_OP_SUB_EXIT, ABD_OP_INT_EXIT:
          begin
            s_d.left  = `ABD_CYC_THREE;
            s_d.state = ABD_ST_BUSY;
            s_d.busy  = 1'b1;
          end
          default: ;
        endcase
      end
    end
    else
    begin
      s_d.left = s_q.left - 2'h1;
      if (s_q.left == `ABD_CYC_ONE)
      begin
        s_d.state = ABD_ST_IDLE;
        s_d.busy  = 1'b0;
        s_d.done  = 1'b1;
        unique case (s_q.op)
          ABD_OP_PAIR_SUM, ABD_OP_PAIR_MINUS:
          begin
            r16   = s_q.res;
            v_c   = (s_q.op == ABD_OP_PAIR_SUM) ? (~pair_val[15] & r16[15])
                                                : (pair_val[15] & ~r16[15]);
            s_d.sreg[`ABD_FLAG_C] = (s_q.op == ABD_OP_PAIR_SUM) ?
                                    (~r16[15] & pair_val[15]) : (r16[15] & ~pair_val[15]);
            s_d.sreg[`ABD_FLAG_V] = v_c;
            s_d.sreg[`ABD_FLAG_N] = r16[15];
            s_d.sreg[`ABD_FLAG_S] = r16[15] ^ v_c;
            s_d.sreg[`ABD_FLAG_Z] = (r16 == `ABD_ZERO16);
            s_d.wr_pair           = 1'b1;
            s_d.pc                = s_q.pc + `ABD_ONE16;
          end
          ABD_OP_MUL, ABD_OP_FRACTION_PRODUCT_UNSIGNED:
          begin
            s_d.res               = prod_q;
            s_d.sreg[`ABD_FLAG_C] = prod_c_q;
            s_d.sreg[`ABD_FLAG_Z] = (prod_q == `ABD_ZERO16);
            s_d.wr_prod           = 1'b1;
            s_d.pc                = s_q.pc + `ABD_ONE16;
          end
          ABD_OP_SUB_EXIT, ABD_OP_INT_EXIT:
          begin
            s_d.pc  = pop_data;
            s_d.sp  = s_q.sp + `ABD_SP_STEP;
            s_d.pop = 1'b1;
            if (s_q.op == ABD_OP_INT_EXIT)
              s_d.sreg[`ABD_FLAG_I] = 1'b1;
          end
          default: s_d.pc = s_q.pend_pc;
        endcase
      end
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s_q         <= '0;
      s_q.sreg    <= `ABD_SREG_RST;
      s_q.pc      <= `ABD_PC_RST;
      s_q.sp      <= `ABD_SP_RST;
      push_data_q <= `ABD_ZERO16;
    end
    else
    begin
      s_q         <= s_d;
      push_data_q <= push_data_d;
    end
  end

  always_comb
  begin
    busy      = s_q.busy;
    done      = s_q.done;
    result    = s_q.res;
    wr_byte   = s_q.wr_byte;
    wr_pair   = s_q.wr_pair;
    wr_prod   = s_q.wr_prod;
    sreg      = s_q.sreg;
    pc        = s_q.pc;
    sp        = s_q.sp;
    push      = s_q.push;
    pop       = s_q.pop;
    push_data = push_data_q;
  end
endmodule : abd_datapath
`default_nettype wire

// ### verif/abd_datapath_chk.sv
`timescale 1ns/100ps
`default_nettype none
module abd_datapath_chk (
  input wire logic             core_clk,  // Core clock
  input wire logic             srst,      // Sync reset
  input wire logic             start,     // Issue request
  input wire abd_pkg::abd_op_t op,        // Operation
  input wire logic [7:0]       dst_val,   // Destination value
  input wire logic [7:0]       src_reg,   // Source value
  input wire logic [7:0]       imm,       // Constant
  input wire logic [15:0]      z_ptr,     // Z pointer
  input wire logic [11:0]      offset,    // Relative offset
  input wire logic [15:0]      pop_data,  // Popped address
  input wire logic             busy,      // Busy
  input wire logic             done,      // Done pulse
  input wire logic [15:0]      result,    // Result
  input wire logic             wr_byte,   // Byte write
  input wire logic             wr_pair,   // Pair write
  input wire logic             wr_prod,   // Product write
  input wire logic [7:0]       sreg,      // Flags
  input wire logic [15:0]      pc,        // Program counter
  input wire logic             push,      // Push pulse
  input wire logic             pop,       // Pop pulse
  input wire logic [15:0]      push_data  // Pushed address
);
  import abd_pkg::*;

  logic        issue;
  logic [15:0] rel_tgt;
  assign issue = start && !busy;
  assign rel_tgt = pc + {{4{offset[11]}}, offset} + 16'h0001;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence s_two_step;
    busy && !done ##1 done && !busy;
  endsequence
  sequence s_exit_tail;
    !done [*3] ##1 done && pop && pc == $past(pop_data);
  endsequence

  a_byte_one_cycle: assert property (issue && op inside {[ABD_OP_ADD:ABD_OP_ADD_CARRY],
    [ABD_OP_SUB:ABD_OP_MINUS_KBRW], [ABD_OP_AND:ABD_OP_SET_REG]} |=> done && wr_byte)
    else $error("byte op did not finish in one cycle");
  a_pair_two_cycles: assert property (issue && op inside {ABD_OP_PAIR_SUM, ABD_OP_PAIR_MINUS}
    |=> s_two_step ##0 wr_pair)
    else $error("pair op timing wrong");
  a_mul_two_cycles: assert property (issue && op inside {ABD_OP_MUL, ABD_OP_FRACTION_PRODUCT_UNSIGNED}
    |=> s_two_step ##0 wr_prod)
    else $error("multiply timing wrong");
  a_sub_value: assert property (issue && op == ABD_OP_SUB
    |=> result[7:0] == $past(dst_val) - $past(src_reg))
    else $error("subtract result wrong");
  a_clear_mask: assert property (issue && op == ABD_OP_CLEAR_BITS
    |=> result[7:0] == ($past(dst_val) & ~$past(imm)))
    else $error("clear bits result wrong");
  a_logic_flags_kept: assert property (issue && op inside {[ABD_OP_AND:ABD_OP_XOR],
    [ABD_OP_SET_BITS:ABD_OP_CLEAR_REG]} |=> (sreg & 8'hf1) == ($past(sreg) & 8'hf1))
    else $error("logic op changed an unlisted flag");
  a_arith_s_kept: assert property (issue && op inside {[ABD_OP_ADD:ABD_OP_ADD_CARRY],
    [ABD_OP_SUB:ABD_OP_MINUS_KBRW], ABD_OP_ARITH_INV} |=> sreg[4] == $past(sreg[4]))
    else $error("arithmetic op changed the sign flag");
  a_rel_target: assert property (issue && op == ABD_OP_REL_BRANCH
    |=> !done ##1 done && pc == $past(rel_tgt, 2))
    else $error("relative branch target wrong");
  a_ind_target: assert property (issue && op == ABD_OP_IND_BRANCH
    |=> !done ##1 done && pc == $past(z_ptr))
    else $error("indirect branch target wrong");
  a_invoke_push: assert property (issue && op inside {ABD_OP_REL_INVOKE, ABD_OP_IND_INVOKE}
    |=> push && push_data == $past(pc) + 16'h0001 ##1 !done ##1 done)
    else $error("invoke push or timing wrong");
  a_exit_pop: assert property (issue && op inside {ABD_OP_SUB_EXIT, ABD_OP_INT_EXIT}
    |=> s_exit_tail)
    else $error("exit pop or timing wrong");
  a_jump_flags: assert property (issue && op inside {[ABD_OP_REL_BRANCH:ABD_OP_SUB_EXIT],
    ABD_OP_EQUAL_SKIP} |=> $stable(sreg))
    else $error("jump changed flags");
endmodule : abd_datapath_chk

bind abd_datapath abd_datapath_chk u_chk (
  .core_clk(core_clk), .srst(srst), .start(start), .op(op), .dst_val(dst_val),
  .src_reg(src_reg), .imm(imm), .z_ptr(z_ptr), .offset(offset), .pop_data(pop_data),
  .busy(busy), .done(done), .result(result), .wr_byte(wr_byte), .wr_pair(wr_pair),
  .wr_prod(wr_prod), .sreg(sreg), .pc(pc), .push(push), .pop(pop), .push_data(push_data)
);
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import abd_pkg::*;
  logic          core_clk = 1'b0;
  logic          srst = 1'b1;
  logic          start = 1'b0;
  abd_op_t       op = ABD_OP_NOP;
  abd_mul_mode_t mul_mode = ABD_MUL_UU;
  logic [7:0]    dst_val = 8'h00;
  logic [7:0]    src_reg = 8'h00;
  logic [7:0]    imm = 8'h00;
  logic [15:0]   pair_val = 16'h0000;
  logic [15:0]   z_ptr = 16'h0000;
  logic [11:0]   offset = 12'h000;
  logic          next_is_long = 1'b0;
  logic [15:0]   pop_data = 16'h0000;
  logic          busy, done, wr_byte, wr_pair, wr_prod, push, pop;
  logic [15:0]   result, pc, sp, push_data;
  logic [7:0]    sreg;
  logic [7:0]    m_sreg = 8'h00;
  logic [15:0]   m_pc = 16'h0000;
  logic [15:0]   m_sp = 16'h045f;
  logic [15:0]   e, p, r, pdat;
  int            mismatches = 0;
  int            check_count = 0;
  int            cyc, pushes, pops;

  abd_datapath dut (
    .core_clk(core_clk), .srst(srst), .start(start), .op(op), .mul_mode(mul_mode),
    .dst_val(dst_val), .src_reg(src_reg), .imm(imm), .pair_val(pair_val), .z_ptr(z_ptr),
    .offset(offset), .next_is_long(next_is_long), .pop_data(pop_data), .busy(busy),
    .done(done), .result(result), .wr_byte(wr_byte), .wr_pair(wr_pair), .wr_prod(wr_prod),
    .sreg(sreg), .pc(pc), .sp(sp), .push(push), .pop(pop), .push_data(push_data)
  );

  always #2 core_clk = ~core_clk;

  task automatic complete_run;
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_flags(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    cmp_val({8'h00, got & m}, {8'h00, exp & m});
  endtask : cmp_flags

  // Flags of an 8-bit add or subtract, unlisted bits carried over
  function automatic logic [15:0] arith(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci, input logic sb, input logic kz);
    logic [8:0] w;
    logic [4:0] l;
    logic [7:0] f;
    w = sb ? {1'b0, a} - {1'b0, b} - 9'(ci) : {1'b0, a} + {1'b0, b} + 9'(ci);
    l = sb ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(ci)
           : {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci);
    f = m_sreg;
    f[0] = w[8];
    f[1] = (w[7:0] == 8'h00) && (!kz || m_sreg[1]);
    f[2] = w[7];
    f[3] = (a[7] == (b[7] ^ sb)) && (w[7] != a[7]);
    f[5] = l[4];
    return {f, w[7:0]};
  endfunction : arith

  function automatic logic [15:0] logic_res(input logic [7:0] v);
    return {m_sreg[7:4], 1'b0, v[7], v == 8'h00, m_sreg[0], v};
  endfunction : logic_res

  task automatic run_op(input abd_op_t o, input logic [7:0] a, input logic [7:0] b);
    @(posedge core_clk);
    #1;
    op = o;
    dst_val = a;
    src_reg = b;
    imm = b;
    start = 1'b1;
    @(posedge core_clk);
    #1;
    start = 1'b0;
    cyc = 1;
    pushes = 0;
    while (done !== 1'b1 && cyc < 8)
    begin
      pushes += (push === 1'b1);
      pdat = (push === 1'b1) ? push_data : pdat;
      @(posedge core_clk);
      #1;
      cyc++;
    end
    pops = (pop === 1'b1);
  endtask : run_op

  task automatic bop(input abd_op_t o, input logic [7:0] a, input logic [7:0] b,
                     input logic [15:0] x, input logic [7:0] m);
    run_op(o, a, b);
    cmp_val(16'(cyc), 16'h0001);
    cmp_val({8'h00, result[7:0]}, {8'h00, x[7:0]});
    cmp_val({15'h0000, wr_byte}, 16'h0001);
    cmp_val(pc, m_pc);
    cmp_flags(sreg, x[15:8], m);
    m_sreg = x[15:8];
  endtask : bop

  task automatic aop(input abd_op_t o, input logic [7:0] a, input logic [7:0] b,
                     input logic ci, input logic kz);
    bop(o, a, b, arith(a, b, ci, o != ABD_OP_ADD && o != ABD_OP_ADD_CARRY, kz), 8'hff);
  endtask : aop

  task automatic wop(input abd_op_t o, input logic [7:0] a, input logic [7:0] b,
                     input logic [15:0] rv, input logic [7:0] x, input logic [1:0] w);
    run_op(o, a, b);
    cmp_val(16'(cyc), 16'h0002);
    cmp_val(result, rv);
    cmp_val({14'h0000, wr_pair, wr_prod}, {14'h0000, w});
    cmp_flags(sreg, x, 8'hff);
    m_pc = m_pc + 16'h0001;
    cmp_val(pc, m_pc);
    m_sreg = x;
  endtask : wop

  task automatic cop(input abd_op_t o, input logic [7:0] a, input logic [7:0] b, input int n,
                     input logic [15:0] epc, input logic [15:0] esp);
    run_op(o, a, b);
    cmp_val(16'(cyc), 16'(n));
    cmp_val(pc, epc);
    cmp_val(sp, esp);
    cmp_flags(sreg, m_sreg, 8'hff);
    cmp_val(16'(pushes), {15'h0000, esp < m_sp});
    cmp_val(16'(pops), {15'h0000, esp > m_sp});
    m_pc = epc;
    m_sp = esp;
  endtask : cop

  initial
  begin
    repeat (6) @(posedge core_clk);
    #1;
    srst = 1'b0;
    cmp_val(sp, 16'h045f);
    cmp_flags(sreg, 8'h00, 8'hff);
    aop(ABD_OP_ADD, 8'h88, 8'h88, 1'b0, 1'b0);
    aop(ABD_OP_ADD_CARRY, 8'h7f, 8'h00, m_sreg[0], 1'b0);
    aop(ABD_OP_SUB, 8'h10, 8'h20, 1'b0, 1'b0);
    aop(ABD_OP_MINUS_BRW, 8'h20, 8'h1f, m_sreg[0], 1'b1);
    aop(ABD_OP_MINUS_K, 8'h05, 8'h05, 1'b0, 1'b0);
    aop(ABD_OP_MINUS_KBRW, 8'h00, 8'h00, m_sreg[0], 1'b1);
    bop(ABD_OP_ARITH_INV, 8'h80, 8'h00, arith(8'h00, 8'h80, 1'b0, 1'b1, 1'b0), 8'hff);
    bop(ABD_OP_AND, 8'hf0, 8'h3c, logic_res(8'h30), 8'hff);
    bop(ABD_OP_MASK_K, 8'h0f, 8'hf0, logic_res(8'h00), 8'hff);
    bop(ABD_OP_OR, 8'h80, 8'h01, logic_res(8'h81), 8'hff);
    bop(ABD_OP_MERGE_K, 8'h00, 8'h00, logic_res(8'h00), 8'hff);
    bop(ABD_OP_XOR, 8'hff, 8'hff, logic_res(8'h00), 8'hff);
    bop(ABD_OP_SET_BITS, 8'h01, 8'h80, logic_res(8'h81), 8'hff);
    bop(ABD_OP_INC, 8'h7f, 8'h00, logic_res(8'h80) | 16'h0800, 8'hff);
    bop(ABD_OP_DEC, 8'h80, 8'h00, logic_res(8'h7f) | 16'h0800, 8'hff);
    bop(ABD_OP_CLEAR_BITS, 8'hff, 8'h0f, logic_res(8'hf0), 8'hff);
    bop(ABD_OP_SET_REG, 8'h5a, 8'h00, {m_sreg, 8'hff}, 8'hff);
    bop(ABD_OP_ZS_CHECK, 8'h00, 8'h00, logic_res(8'h00), 8'hff);
    bop(ABD_OP_CLEAR_REG, 8'h5a, 8'h00, logic_res(8'h00), 8'hff);
    bop(ABD_OP_INVERT, 8'h0f, 8'h00, logic_res(8'hf0) | 16'h0100, 8'hff);
    pair_val = 16'hffff;
    wop(ABD_OP_PAIR_SUM, 8'h00, 8'hc1, 16'h0000, {m_sreg[7:5], 5'b00011}, 2'b10);
    pair_val = 16'h8000;
    wop(ABD_OP_PAIR_MINUS, 8'h00, 8'hc1, 16'h7fff, {m_sreg[7:5], 5'b11000}, 2'b10);
    for (int i = 0; i < 6; i++)
    begin
      mul_mode = abd_mul_mode_t'(i % 3);
      p = ((i % 3 == 0) ? 16'h0080 : 16'hff80) * ((i % 3 == 1) ? 16'hffff : 16'h00ff);
      r = (i > 2) ? {p[14:0], 1'b0} : p;
      wop((i > 2) ? ABD_OP_FRACTION_PRODUCT_UNSIGNED : ABD_OP_MUL, 8'h80, 8'hff, r,
          {m_sreg[7:2], r == 16'h0000, p[15]}, 2'b01);
    end
    offset = 12'h800;
    cop(ABD_OP_REL_BRANCH, 8'h00, 8'h00, 2, m_pc + 16'hf801, m_sp);
    z_ptr = 16'h1234;
    cop(ABD_OP_IND_BRANCH, 8'h00, 8'h00, 2, 16'h1234, m_sp);
    offset = 12'h010;
    e = m_pc + 16'h0001;
    cop(ABD_OP_REL_INVOKE, 8'h00, 8'h00, 3, m_pc + 16'h0011, m_sp - 16'h0002);
    cmp_val(pdat, e);
    e = m_pc + 16'h0001;
    cop(ABD_OP_IND_INVOKE, 8'h00, 8'h00, 3, 16'h1234, m_sp - 16'h0002);
    cmp_val(pdat, e);
    pop_data = 16'h0abc;
    cop(ABD_OP_SUB_EXIT, 8'h00, 8'h00, 4, 16'h0abc, m_sp + 16'h0002);
    m_sreg[7] = 1'b1;
    pop_data = 16'h1236;
    cop(ABD_OP_INT_EXIT, 8'h00, 8'h00, 4, 16'h1236, m_sp + 16'h0002);
    cop(ABD_OP_EQUAL_SKIP, 8'h3c, 8'h3c, 2, m_pc + 16'h0002, m_sp);
    next_is_long = 1'b1;
    cop(ABD_OP_EQUAL_SKIP, 8'h3c, 8'h3c, 3, m_pc + 16'h0003, m_sp);
    cop(ABD_OP_EQUAL_SKIP, 8'h3c, 8'h3d, 1, m_pc + 16'h0001, m_sp);
    complete_run;
  end

  initial
  begin
    repeat (2000) @(posedge core_clk);
    mismatches++;
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
